// >>> dts_datapath_test.sv
// Datapath test control, pattern insertion and calibration status bank
module dts_datapath_test
    import dts_pkg::*;
#(
    parameter int unsigned N_CH   = 16,
    parameter int unsigned N_LANE = 2
) (
    // Core clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    // Configuration port
    input  wire logic       spi_clk_in,
    input  wire logic       spi_cs_n_in,
    input  wire logic       spi_mosi_in,
    output logic            spi_miso_out,
    // Calibration results
    input  wire logic       cal_done_in,
    input  wire logic [5:0] cal_chan_in,
    input  wire logic [7:0] cal_count_in,
    output logic [15:0]     cal_valid_out,
    // Pixel stream in
    input  dts_word_t       pix_in,
    input  wire logic       pix_valid_in,
    output logic            pix_ready_out,
    // Stream out
    output dts_word_t       dout_out,
    output logic            dout_valid_out,
    input  wire logic       dout_ready_in,
    // Converter debug
    input  wire logic [9:0] adc_a_in,
    input  wire logic [9:0] adc_b_in,
    output logic [9:0]      adc_dbg_out
);

////////////////////////////////////////////////////////////////////////////////
// Parameter checks
if (N_CH < 1 || N_CH > 16) begin : g_chk_ch
    $error("N_CH must be 1 to 16");
end
if (N_LANE != 2) begin : g_chk_lane
    $error("N_LANE must be 2");
end

////////////////////////////////////////////////////////////////////////////////
// State
dts_core_t  s;
dts_core_t  next_s;
dts_spi_t   ss;
dts_spi_t   next_ss;
logic [8:0] need;
logic       lack;
logic       test;
logic       loose;
logic       src_v;
logic       push;
logic       pop;
logic [1:0] c;
dts_word_t  w;
logic [25:0] nsh;
logic [15:0] ld;

// Register read mux
function automatic logic [15:0] rd_word(input dts_core_t r, input logic [8:0] a);
    case (a)
        A_BLKCAL: rd_word = r.blkcal;
        A_FLT0:   rd_word = r.flt;
        A_RSVB:   rd_word = RST_RSVB;
        A_TCTL:   rd_word = r.tctl;
        A_PLOW:   rd_word = r.plow;
        A_PHIGH:  rd_word = r.phigh;
        default:  rd_word = RST_FLT;
    endcase
endfunction

////////////////////////////////////////////////////////////////////////////////
// Core domain
always_comb begin
    next_s = s;
    need = 9'h001 << s.blkcal[F_SAMP +: 3];
    lack = {1'b0, cal_count_in} < need;
    // Calibration flags
    if (cal_done_in && cal_chan_in < 6'(N_CH)) begin
        next_s.flt[cal_chan_in[3:0]] = lack;
        next_s.cal_ok[cal_chan_in[3:0]] = !lack;
    end
    // Register requests from the link
    next_s.req_sync = {s.req_sync[1:0], ss.req_tog};
    if (s.req_sync[1] == s.req_sync[2] && s.req_sync[2] != s.ack_tog) begin
        next_s.ack_tog = s.req_sync[2];
        next_s.rdata = rd_word(s, ss.req.addr);
        if (ss.req.wr) begin
            case (ss.req.addr)
                A_BLKCAL: next_s.blkcal = ss.req.data;
                A_TCTL:   next_s.tctl = ss.req.data & TCTL_MASK;
                A_PLOW:   next_s.plow = ss.req.data;
                A_PHIGH:  next_s.phigh = ss.req.data;
                default:  next_s.rdata = rd_word(s, ss.req.addr);
            endcase
        end
    end
    // Source selection
    test = s.tctl[B_PAT] | s.tctl[B_PRBS];
    loose = test & !s.tctl[B_FRAME];
    src_v = loose | pix_valid_in;
    w = pix_in;
    if (loose) begin
        w.sof = 1'b0;
        w.eol = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
        if (s.tctl[B_PRBS]) begin
            w.lane[i] = s.lfsr[5*i +: 10];
        end else if (s.tctl[B_PAT]) begin
            w.lane[i] = {s.phigh[2*i +: 2], s.plow[8*i +: 8]}
                        + (s.tctl[B_INC] ? s.inc : 10'h000);
        end
    end
    push = src_v & s.rdy;
    pop = s.vld & dout_ready_in;
    // Ramp and sequence advance
    if (!(s.tctl[B_PAT] && s.tctl[B_INC])) begin
        next_s.inc = 10'h000;
    end else if (push) begin
        next_s.inc = s.inc + 10'h001;
    end
    if (push && s.tctl[B_PRBS]) begin
        next_s.lfsr = {s.lfsr[13:0], s.lfsr[14] ^ s.lfsr[13]};
    end
    // Two-entry buffer
    c = s.cnt;
    if (pop) begin
        next_s.slot[0] = s.slot[1];
        c = c - 2'd1;
    end
    if (push) begin
        next_s.slot[c[0]] = w;
        c = c + 2'd1;
    end
    next_s.cnt = c;
    next_s.vld = c != 2'd0;
    next_s.rdy = c != 2'd2;
    // Converter debug
    next_s.adc_dbg = s.tctl[B_ADC_SEL] ? adc_b_in : adc_a_in;
    if (rst_in) begin
        next_s = '0;
        next_s.blkcal = RST_BLKCAL;
        next_s.tctl = RST_TCTL;
        next_s.plow = RST_PLOW;
        next_s.phigh = RST_PHIGH;
        next_s.flt = RST_FLT;
        next_s.lfsr = LFSR_SEED;
    end
end

always_ff @(posedge core_clk_in) begin
    s <= next_s;
end

assign cal_valid_out = s.cal_ok;
assign pix_ready_out = s.rdy;
assign dout_out = s.slot[0];
assign dout_valid_out = s.vld;
assign adc_dbg_out = s.adc_dbg;

////////////////////////////////////////////////////////////////////////////////
// Link domain
always_comb begin
    next_ss = ss;
    ld = 16'h0000;
    next_ss.rst_sync = {ss.rst_sync[1:0], rst_in};
    if (ss.rst_sync[1] == ss.rst_sync[2]) begin
        next_ss.srst = ss.rst_sync[2];
    end
    next_ss.ack_sync = {ss.ack_sync[1:0], s.ack_tog};
    if (ss.ack_sync[1] == ss.ack_sync[2]) begin
        next_ss.ack_seen = ss.ack_sync[2];
    end
    nsh = {ss.sh[24:0], spi_mosi_in};
    if (spi_cs_n_in) begin
        next_ss.cnt = 6'h00;
        next_ss.miso = 1'b0;
    end else begin
        next_ss.sh = nsh;
        if (ss.cnt != SPI_CNT_MAX) begin
            next_ss.cnt = ss.cnt + 6'h01;
        end
        next_ss.miso = ss.out[15];
        next_ss.out = {ss.out[14:0], 1'b0};
        if (ss.cnt == SPI_RD_CNT && !nsh[9]) begin
            next_ss.req = {1'b0, nsh[8:0], 16'h0000};
            next_ss.req_tog = !ss.req_tog;
        end
        if (ss.cnt == SPI_WR_CNT && nsh[25]) begin
            next_ss.req = {1'b1, nsh[24:0]};
            next_ss.req_tog = !ss.req_tog;
        end
        if (ss.cnt == SPI_LD_CNT) begin
            if (ss.ack_seen == ss.req_tog) begin
                ld = s.rdata;
            end
            next_ss.miso = ld[15];
            next_ss.out = {ld[14:0], 1'b0};
        end
    end
    if (ss.srst) begin
        next_ss.ack_sync = 3'b000;
        next_ss.ack_seen = 1'b0;
        next_ss.cnt = 6'h00;
        next_ss.sh = 26'h0000000;
        next_ss.req = '0;
        next_ss.req_tog = 1'b0;
        next_ss.out = 16'h0000;
        next_ss.miso = 1'b0;
    end
end

always_ff @(posedge spi_clk_in) begin
    ss <= next_ss;
end

assign spi_miso_out = ss.miso;

////////////////////////////////////////////////////////////////////////////////
// Assertions
default clocking cb @(posedge core_clk_in);
endclocking
default disable iff (rst_in);

sequence seq_cal_lack;
    cal_done_in && cal_chan_in < 6'(N_CH) && lack;
endsequence

sequence seq_pat_push;
    push && s.tctl[B_PAT] && !s.tctl[B_PRBS];
endsequence

sequence seq_ramp_push;
    seq_pat_push ##0 s.tctl[B_INC] && $stable(s.plow) && $stable(s.phigh);
endsequence

AST_FLT_SET: assert property (
    seq_cal_lack |=> s.flt[$past(cal_chan_in[3:0])])
    else $error("Fault flag missed a short calibration");

AST_INVALID: assert property (
    seq_cal_lack |=> !cal_valid_out[$past(cal_chan_in[3:0])] ##1 (s.flt & s.cal_ok) == 16'h0000)
    else $error("Faulty channel reported valid");

AST_ABSENT: assert property (
    cal_done_in && cal_chan_in >= 6'(N_CH) |=> $stable(s.flt))
    else $error("Absent channel changed a flag");

AST_PAT_CONST: assert property (
    seq_pat_push ##0 !s.tctl[B_INC] |-> w.lane[0] == {s.phigh[1:0], s.plow[7:0]})
    else $error("Constant pattern word wrong");

AST_RAMP: assert property (
    seq_ramp_push ##1 seq_ramp_push |-> w.lane[0] == $past(w.lane[0]) + 10'h001)
    else $error("Ramp pattern did not step by one");

AST_PRBS: assert property (
    push && s.tctl[B_PRBS] |-> w.lane[0] == s.lfsr[9:0] ##1 s.lfsr[14:1] == $past(s.lfsr[13:0]))
    else $error("Random sequence not inserted");

AST_LOOSE: assert property (
    loose |-> src_v && !w.sof && !w.eol)
    else $error("Unframed test output carries framing");

AST_FRAMED: assert property (
    test && s.tctl[B_FRAME] && !pix_valid_in |-> !push)
    else $error("Framed test output ran without a frame");

AST_DBG: assert property (
    1'b1 |=> adc_dbg_out == ($past(s.tctl[B_ADC_SEL]) ? $past(adc_b_in) : $past(adc_a_in)))
    else $error("Debug pins show wrong converter");

AST_HOLD: assert property (
    dout_valid_out && !dout_ready_in |=> dout_valid_out && $stable(dout_out))
    else $error("Stalled output word lost");

sequence seq_cal_take;
    cal_done_in && cal_chan_in < 6'(N_CH);
endsequence

AST_FLT_CLR: assert property (
    seq_cal_take ##0 !lack |=>
        !s.flt[$past(cal_chan_in[3:0])] && cal_valid_out[$past(cal_chan_in[3:0])])
    else $error("Good calibration left a fault flag");

AST_FLT_HOLD: assert property (
    !cal_done_in |=> $stable(s.flt) && $stable(cal_valid_out))
    else $error("Fault flags changed without a result");

AST_NEED_ZERO: assert property (
    seq_cal_take ##0 cal_count_in == 8'h00 |=> s.flt[$past(cal_chan_in[3:0])])
    else $error("Empty sample set not flagged");

AST_NEED_MAX: assert property (
    seq_cal_take ##0 cal_count_in[7] |=> !s.flt[$past(cal_chan_in[3:0])])
    else $error("Full sample set flagged");

AST_NEED_ONE: assert property (
    seq_cal_take ##0 s.blkcal[F_SAMP +: 3] == 3'h0 && cal_count_in != 8'h00 |=>
        !s.flt[$past(cal_chan_in[3:0])])
    else $error("Single sample requirement misjudged");

AST_TCTL_MASK: assert property (
    s.tctl[15:5] == 11'h000)
    else $error("Unused control bits set");

AST_PIX_WORD: assert property (
    push && !test |-> w == pix_in)
    else $error("Pixel word altered outside test mode");

AST_FIRST_OUT: assert property (
    push && s.cnt == 2'd0 |=> dout_valid_out && dout_out == $past(w))
    else $error("Word into empty buffer not shown");

AST_PAT_LANE1: assert property (
    seq_pat_push ##0 !s.tctl[B_INC] |-> w.lane[1] == {s.phigh[3:2], s.plow[15:8]})
    else $error("Second lane pattern word wrong");

AST_RAMP_CLR: assert property (
    !(s.tctl[B_PAT] && s.tctl[B_INC]) |=> s.inc == 10'h000)
    else $error("Ramp not cleared while off");

AST_RAMP_HOLD: assert property (
    s.tctl[B_PAT] && s.tctl[B_INC] && !push |=> $stable(s.inc))
    else $error("Ramp moved without a word");

AST_PRBS_HOLD: assert property (
    !(push && s.tctl[B_PRBS]) |=> $stable(s.lfsr))
    else $error("Random sequence moved without a word");

AST_PRBS_LIVE: assert property (
    s.lfsr != 15'h0000)
    else $error("Random sequence stuck at zero");

AST_PRBS_LANE1: assert property (
    push && s.tctl[B_PRBS] |-> w.lane[1] == s.lfsr[14:5])
    else $error("Second lane random word wrong");

endmodule

// >>> dts_pkg.sv
// Constants, register map and carrier types of the datapath test bank
package dts_pkg;

////////////////////////////////////////////////////////////////////////////////
// Register addresses
localparam logic [8:0] A_BLKCAL = 9'h080;
localparam logic [8:0] A_FLT0   = 9'h088;
localparam logic [8:0] A_FLT1   = 9'h089;
localparam logic [8:0] A_FLT2   = 9'h08a;
localparam logic [8:0] A_FLT3   = 9'h08b;
localparam logic [8:0] A_RSVA   = 9'h08c;
localparam logic [8:0] A_RSVB   = 9'h08d;
localparam logic [8:0] A_TCTL   = 9'h090;
localparam logic [8:0] A_RSVC   = 9'h091;
localparam logic [8:0] A_PLOW   = 9'h092;
localparam logic [8:0] A_PHIGH  = 9'h096;

// Reset values
localparam logic [15:0] RST_BLKCAL = 16'h4008;
localparam logic [15:0] RST_FLT    = 16'h0000;
localparam logic [15:0] RST_RSVA   = 16'h0000;
localparam logic [15:0] RST_RSVB   = 16'hffff;
localparam logic [15:0] RST_TCTL   = 16'h0000;
localparam logic [15:0] RST_RSVC   = 16'h0000;
localparam logic [15:0] RST_PLOW   = 16'h0100;
localparam logic [15:0] RST_PHIGH  = 16'h0000;

// Field positions
localparam int unsigned B_PAT     = 0;
localparam int unsigned B_INC     = 1;
localparam int unsigned B_PRBS    = 2;
localparam int unsigned B_FRAME   = 3;
localparam int unsigned B_ADC_SEL = 4;
localparam int unsigned F_SAMP    = 8;
localparam logic [15:0] TCTL_MASK = 16'h001f;

// Serial frame bit counts
localparam logic [5:0] SPI_RD_CNT = 6'h09;
localparam logic [5:0] SPI_LD_CNT = 6'h15;
localparam logic [5:0] SPI_WR_CNT = 6'h19;
localparam logic [5:0] SPI_CNT_MAX = 6'h3f;

// Sequence generator seed
localparam logic [14:0] LFSR_SEED = 15'h7fff;

////////////////////////////////////////////////////////////////////////////////
// Carriers
typedef struct packed {
    logic            sof;
    logic            eol;
    logic [1:0][9:0] lane;
} dts_word_t;

typedef struct packed {
    logic        wr;
    logic [8:0]  addr;
    logic [15:0] data;
} dts_req_t;

// Core domain state
typedef struct packed {
    logic [15:0]     blkcal;
    logic [15:0]     tctl;
    logic [15:0]     plow;
    logic [15:0]     phigh;
    logic [15:0]     flt;
    logic [15:0]     cal_ok;
    logic [2:0]      req_sync;
    logic            ack_tog;
    logic [15:0]     rdata;
    logic [9:0]      inc;
    logic [14:0]     lfsr;
    dts_word_t [1:0] slot;
    logic [1:0]      cnt;
    logic            vld;
    logic            rdy;
    logic [9:0]      adc_dbg;
} dts_core_t;

// Link domain state
typedef struct packed {
    logic [2:0]  rst_sync;
    logic        srst;
    logic [2:0]  ack_sync;
    logic        ack_seen;
    logic [5:0]  cnt;
    logic [25:0] sh;
    dts_req_t    req;
    logic        req_tog;
    logic [15:0] out;
    logic        miso;
} dts_spi_t;

endpackage

// >>> dts_host.sv
// Host link master and stream receiver model for the datapath test bank
module dts_host
    import dts_pkg::*;
(
    // Clocks
    input  wire logic core_clk_in,
    input  wire logic spi_clk_in,
    // Configuration link
    input  wire logic spi_miso_in,
    output logic      spi_cs_n_out,
    output logic      spi_mosi_out,
    // Stream receiver
    input  dts_word_t dout_in,
    input  wire logic dout_valid_in,
    output logic      dout_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    dts_word_t got[$];
    int        stall = 0;

    initial begin
        spi_cs_n_out = 1'b1;
        spi_mosi_out = 1'b0;
        dout_ready_out = 1'b1;
    end

    // Ready: free, random stalls, or held off
    always @(negedge core_clk_in) begin
        dout_ready_out <= (stall == 0) || (stall == 1 && $urandom % 4 == 0);
    end

    always @(posedge core_clk_in) begin
        if (dout_valid_in && dout_ready_out) begin
            got.push_back(dout_in);
        end
    end

    // Write frame 26 bits, read frame 38 bits; idle data line toggles
    task automatic xfer(input logic wr, input logic [8:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        logic [25:0] h;
        int          n;
        h = {wr, a, d};
        n = wr ? 26 : 38;
        q = 16'h0000;
        @(negedge spi_clk_in);
        spi_cs_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_mosi_out = (i < 26) ? h[25 - i] : ~spi_mosi_out;
            @(negedge spi_clk_in);
            if (i >= 21 && i <= 36) begin
                q = {q[14:0], spi_miso_in};
            end
        end
        spi_cs_n_out = 1'b1;
        spi_mosi_out = ~spi_mosi_out;
        @(negedge spi_clk_in);
    endtask
endmodule

// >>> dts_datapath_test_tb.sv
// Self-checking bench of the datapath test bank
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module dts_datapath_test_tb
    import dts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        spi_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cs_n, mosi, miso, ready, dvalid, pix_ready;
    logic        pix_valid = 1'b0;
    logic        cal_done = 1'b0;
    logic [5:0]  cal_chan = 6'h00;
    logic [7:0]  cal_count = 8'h00;
    logic [15:0] cal_valid, q, wv, plow, phigh;
    logic [15:0] tctl = 16'h0000;
    logic [15:0] flt = 16'h0000;
    logic [15:0] vld = 16'h0000;
    logic [9:0]  adc_a = 10'h000;
    logic [9:0]  adc_b = 10'h000;
    logic [9:0]  adc_dbg;
    logic [9:0]  ramp = 10'h000;
    logic [14:0] lfsr = LFSR_SEED;
    dts_word_t   pix = '0;
    dts_word_t   dout, w;
    dts_word_t   exp_q[$];
    int          fail_count = 0;
    int          num_checks = 0;
    int          run = 0;
    int          took = 0;
    int          n;
    logic [8:0]  ra[12] = '{A_BLKCAL, A_FLT0, A_FLT1, A_FLT2, A_FLT3, A_RSVA, A_RSVB, A_TCTL,
                            A_RSVC, A_PLOW, A_PHIGH, 9'h0a0};
    logic [15:0] sh[12] = '{RST_BLKCAL, RST_FLT, RST_FLT, RST_FLT, RST_FLT, RST_RSVA, RST_RSVB,
                            RST_TCTL, RST_RSVC, RST_PLOW, RST_PHIGH, 16'h0000};
    logic [15:0] rm[12] = '{16'hffff, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, TCTL_MASK,
                            16'h0, 16'hffff, 16'h000f, 16'h0};
    logic [15:0] um[2] = '{16'h0003, 16'h0004};

    dts_datapath_test i_dts_datapath_test (.core_clk_in(core_clk), .rst_in(rst),
        .spi_clk_in(spi_clk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
        .cal_done_in(cal_done), .cal_chan_in(cal_chan), .cal_count_in(cal_count),
        .cal_valid_out(cal_valid), .pix_in(pix), .pix_valid_in(pix_valid),
        .pix_ready_out(pix_ready), .dout_out(dout), .dout_valid_out(dvalid),
        .dout_ready_in(ready), .adc_a_in(adc_a), .adc_b_in(adc_b), .adc_dbg_out(adc_dbg));
    dts_host i_dts_host (.core_clk_in(core_clk), .spi_clk_in(spi_clk), .spi_miso_in(miso),
        .spi_cs_n_out(cs_n), .spi_mosi_out(mosi), .dout_in(dout), .dout_valid_in(dvalid),
        .dout_ready_out(ready));

    initial forever #2.5 core_clk = ~core_clk;
    initial begin
        #1.3;
        forever #6 spi_clk = ~spi_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stream source and reference model
    always @(posedge core_clk) begin
        if (pix_ready && (pix_valid || ((tctl[0] || tctl[2]) && !tctl[3]))) begin
            w = pix;
            if (tctl[2]) begin
                w.lane[0] = lfsr[9:0];
                w.lane[1] = lfsr[14:5];
            end else if (tctl[0]) begin
                w.lane[0] = {phigh[1:0], plow[7:0]} + ramp;
                w.lane[1] = {phigh[3:2], plow[15:8]} + ramp;
            end
            if ((tctl[0] || tctl[2]) && !tctl[3]) begin
                w.sof = 1'b0;
                w.eol = 1'b0;
            end
            exp_q.push_back(w);
            took = pix_valid;
            if (tctl[2]) lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
            ramp = (tctl[0] && tctl[1]) ? ramp + 10'h001 : 10'h000;
        end
    end
    always @(negedge core_clk) begin
        if (!pix_valid || took != 0) begin
            pix_valid <= (run != 0) && ($urandom % 3 != 0);
            pix <= dts_word_t'(22'($urandom));
        end
        took <= 0;
    end

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        i_dts_host.xfer(1'b1, a, d, q);
        foreach (ra[i]) if (ra[i] == a) sh[i] = (d & rm[i]) | (sh[i] & ~rm[i]);
        repeat (10) @(negedge core_clk);
    endtask
    task automatic rd(input logic [8:0] a, input logic [15:0] e);
        i_dts_host.xfer(1'b0, a, 16'h0000, q);
        `CHK("register read", e, q)
    endtask
    task automatic set_mode(input logic [15:0] t);
        wr(A_TCTL, t);
        tctl = t & TCTL_MASK;
        if (!(t[0] && t[1])) ramp = 10'h000;
    endtask
    task automatic drain();
        i_dts_host.stall = 0;
        for (n = 0; n < 400 && (pix_valid || dvalid || i_dts_host.got.size() != exp_q.size());
             n++) @(negedge core_clk);
        if (n == 400) begin
            fail_count++;
            close_out();
        end
        foreach (exp_q[i]) `CHK("stream word", exp_q[i], i_dts_host.got[i])
        exp_q.delete();
        i_dts_host.got.delete();
    endtask
    task automatic stream(input logic [15:0] t);
        set_mode(t);
        i_dts_host.stall = 1;
        run = 1;
        repeat (80) @(negedge core_clk);
        run = 0;
        drain();
    endtask

    initial begin
        void'($urandom(19181));
        repeat (8) @(negedge core_clk);
        repeat (4) @(posedge spi_clk);
        @(negedge core_clk);
        rst = 1'b0;
        repeat (20) @(negedge core_clk);
        foreach (ra[i]) rd(ra[i], sh[i]);
        plow = 16'($urandom);
        phigh = 16'($urandom) & 16'h000f;
        wr(A_PLOW, plow);
        wr(A_PHIGH, phigh);
        stream(16'h000d);
        stream(16'h0009);
        stream(16'h000b);
        stream(16'h0000);
        // Unframed: enter and leave with the output buffer full
        foreach (um[k]) begin
            i_dts_host.stall = 2;
            run = 1;
            repeat (20) @(negedge core_clk);
            run = 0;
            set_mode(um[k]);
            i_dts_host.stall = 1;
            repeat (100) @(negedge core_clk);
            i_dts_host.stall = 2;
            repeat (10) @(negedge core_clk);
            set_mode(16'h0000);
            drain();
        end
        for (int r = 0; r < 3; r++) begin
            n = $urandom_range(0, 7);
            wv = 16'($urandom);
            wv[10:8] = 3'(n);
            wr(A_BLKCAL, wv);
            for (int c = 0; c < 18; c++) begin
                cal_chan = (c < 16) ? 6'(c) : 6'($urandom_range(16, 63));
                cal_count = 8'($urandom) >> (7 - n);
                cal_done = 1'b1;
                @(negedge core_clk);
                cal_done = 1'b0;
                if (c < 16) vld[c] = (int'(cal_count) >= (1 << n));
                if (c < 16) flt[c] = !vld[c];
                `CHK("calibration valid", vld, cal_valid)
            end
            rd(A_FLT0, flt);
        end
        sh[1] = flt;
        for (int s = 0; s < 2; s++) begin
            set_mode(16'(s << 4));
            repeat (8) begin
                adc_a = 10'($urandom);
                adc_b = 10'($urandom);
                @(negedge core_clk);
                `CHK("converter debug", (s != 0) ? adc_b : adc_a, adc_dbg)
            end
        end
        foreach (ra[i]) begin
            wv = (ra[i] == A_PHIGH) ? 16'($urandom) & 16'h000f : 16'($urandom);
            wr(ra[i], wv);
            rd(ra[i], sh[i]);
        end
        close_out();
    end
endmodule
